// ===== rtl/scan_sequencer.sv
// Rolling-shutter scan sequencer: drives row reset and row read strobes
// for the two sensor halves in the selected scan pattern.
// Assumes clk_sys_i is the 40 MHz sequencer clock and trig_i is an
// asynchronous pin; registers are reached over a plain strobe port.
//
// Overview of operation
// [RL1] Standard pattern reads both halves together, centre outwards row by row.
// [RL2] Single sweep scans whole sensor top-down or bottom-up on one port.
// [RL3] Single sweep takes twice the rows per frame, halving frame rate.
// [RL4] Dual patterns read both halves at once, each following its light.
// [RL5] Pattern choice: centre-out plus three further dual-half directions.
// [RL6] Alternation reverses sweep direction on every successive image.
// [RL7] Programmable delay sits between external trigger and acquisition start.
// [RL8] Exposure window height in rows; exposure equals height over line speed.
// [RL9] Line speed clamped to 2.98-41.67 or 7.43-104 rows per millisecond.
// [RL10] Speed ranges apply at the 216 MHz and 540 MHz pixel rates.
// [RL11] Outside party should match its scanner speed to the sensor line rate.
// [RL12] One row time is a full row readout of 2624 pixel clocks.
// [RL13] Half-frame height comes from the region of interest; full is 1080.
// [RL14] Settings are captured at acquisition start and held until stop.
// [RL15] Trigger delay counted in clocks; first row reset when it expires.
//
// Local design decisions: the register offsets and strobed register access.
`include "rss_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module scan_sequencer import rss_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int MAX_ROWS_HALF = `FULL_ROWS_HALF
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  output logic [31:0] rd_data_o,
  input wire logic trig_i,
  output logic row_rst_stb_a_o,
  output logic [ADDR_W-1:0] row_rst_addr_a_o,
  output logic row_rd_stb_a_o,
  output logic [ADDR_W-1:0] row_rd_addr_a_o,
  output logic row_rst_stb_b_o,
  output logic [ADDR_W-1:0] row_rst_addr_b_o,
  output logic row_rd_stb_b_o,
  output logic [ADDR_W-1:0] row_rd_addr_b_o,
  output logic frame_start_o,
  output logic frame_done_o,
  output logic scan_dir_o,
  output logic busy_o
);

  generate
    if (MAX_ROWS_HALF < 1 || 2 * MAX_ROWS_HALF > (1 << ADDR_W) || ADDR_W > 12) begin : g_chk
      $error("scan_sequencer: MAX_ROWS_HALF does not fit ADDR_W");
    end
  endgenerate
  localparam logic [15:0] ROW_MIN_SLOW_C = 16'(`ROW_MIN_SLOW);
  localparam logic [15:0] ROW_MIN_FAST_C = 16'(`ROW_MIN_FAST);
  localparam logic [31:0] SPD_NUMER_C = 32'(`SPD_NUMER);
  localparam logic [11:0] MAX_ROWS_C = 12'(MAX_ROWS_HALF);
  // Clamp a requested speed into the range of the selected pixel rate
  function automatic logic [15:0] clamp_speed(input logic [15:0] spd, input logic fast);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = fast ? `SPD_MIN_FAST : `SPD_MIN_SLOW;
    hi = fast ? `SPD_MAX_FAST : `SPD_MAX_SLOW;
    if (spd < lo) begin
      return lo;
    end else if (spd > hi) begin
      return hi;
    end
    return spd;
  endfunction
  // Physical row of sweep index idx; half a is rows 0..h-1 (top edge at 0)
  function automatic logic [ADDR_W-1:0] row_addr(input logic [12:0] idx,
      input logic half_b, input scan_pattern_type pat, input logic rev,
      input logic [12:0] h);
    logic down;
    logic [12:0] r;
    down = 1'b1;
    case (pat)
      PAT_CENTRE_OUT: down = half_b; // RL1
      PAT_EDGES_IN: down = !half_b;
      PAT_BOTH_DOWN: down = 1'b1;
      PAT_BOTH_UP: down = 1'b0;
      PAT_SINGLE_DOWN: down = 1'b1;
      PAT_SINGLE_UP: down = 1'b0;
      default: down = 1'b1;
    endcase
    down = down ^ rev; // RL6
    if (pat == PAT_SINGLE_DOWN || pat == PAT_SINGLE_UP) begin
      r = down ? idx : (13'((h << 1) - 13'd1) - idx); // RL2
    end else if (!half_b) begin
      r = down ? idx : (h - 13'd1 - idx);
    end else begin
      r = down ? (h + idx) : (13'((h << 1) - 13'd1) - idx);
    end
    return r[ADDR_W-1:0];
  endfunction
  // Trigger pin synchroniser
  logic trig_meta_ff;
  logic trig_sync_ff;
  logic trig_prev_ff;
  logic trig_edge;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_meta_ff <= 1'b0;
      trig_sync_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else begin
      trig_meta_ff <= trig_i;
      trig_sync_ff <= trig_meta_ff;
      trig_prev_ff <= trig_sync_ff;
    end
  end
  assign trig_edge = trig_sync_ff && !trig_prev_ff;
  // Software settings
  logic acq_en_ff;
  logic alt_en_ff;
  logic [2:0] pat_ff;
  logic fast_ff;
  logic [31:0] trig_dly_ff;
  logic [11:0] win_h_ff;
  logic [15:0] line_spd_ff;
  logic [11:0] roi_h_ff;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acq_en_ff <= 1'b0;
      alt_en_ff <= 1'b0;
      pat_ff <= 3'h0;
      fast_ff <= 1'b0;
      trig_dly_ff <= `RST_TRIG_DLY;
      win_h_ff <= `RST_WIN_H;
      line_spd_ff <= `RST_LINE_SPD;
      roi_h_ff <= MAX_ROWS_C;
    end else if (wr_stb_i) begin
      case (addr_i)
        `REG_CTRL: begin
          acq_en_ff <= wr_data_i[`CTRL_ACQ_EN];
          alt_en_ff <= wr_data_i[`CTRL_ALT_EN];
          pat_ff <= wr_data_i[`CTRL_PAT_HI:`CTRL_PAT_LO];
          fast_ff <= wr_data_i[`CTRL_FAST];
        end
        `REG_TRIG_DLY: trig_dly_ff <= wr_data_i;
        `REG_WIN_H: win_h_ff <= wr_data_i[11:0];
        `REG_LINE_SPD: line_spd_ff <= wr_data_i[15:0];
        `REG_ROI_H: roi_h_ff <= wr_data_i[11:0];
        default: ;
      endcase
    end
  end
  // Settings captured at acquisition start
  scan_pattern_type sh_pat_ff;
  logic sh_alt_ff;
  logic [31:0] sh_dly_ff;
  logic [12:0] sh_win_ff;
  logic [12:0] sh_half_ff;
  logic [12:0] sh_rows_ff;
  logic [15:0] sh_spd_ff;
  logic [15:0] sh_min_row_ff;
  logic [15:0] period_ff;
  seq_state_type state_ff;
  logic [31:0] dly_cnt_ff;
  logic [15:0] row_cnt_ff;
  logic [12:0] step_ff;
  logic dir_rev_ff;
  logic [15:0] frame_cnt_ff;
  logic div_start_ff;
  logic [31:0] div_quot;
  logic div_done;
  logic row_tick;
  logic last_step;
  logic single;
  assign single = (sh_pat_ff == PAT_SINGLE_DOWN) || (sh_pat_ff == PAT_SINGLE_UP);
  assign row_tick = (state_ff == ST_SCAN) && (row_cnt_ff == 16'h0000);
  assign last_step = (step_ff == 13'(sh_rows_ff + sh_win_ff - 13'd1));
  row_period_div #(.W(32)) u_div (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .start_i(div_start_ff),
    .dividend_i(SPD_NUMER_C),
    .divisor_i({16'h0000, sh_spd_ff}),
    .quot_o(div_quot),
    .done_o(div_done)
  );
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sh_pat_ff <= PAT_CENTRE_OUT;
      sh_alt_ff <= 1'b0;
      sh_dly_ff <= '0;
      sh_win_ff <= 13'h0001;
      sh_half_ff <= 13'h0001;
      sh_rows_ff <= 13'h0001;
      sh_spd_ff <= `SPD_MIN_SLOW;
      sh_min_row_ff <= ROW_MIN_SLOW_C;
    end else if (state_ff == ST_IDLE && acq_en_ff) begin
      sh_pat_ff <= (pat_ff > 3'(PAT_SINGLE_UP)) ? PAT_CENTRE_OUT : scan_pattern_type'(pat_ff); // RL5
      sh_alt_ff <= alt_en_ff; // RL14
      sh_dly_ff <= trig_dly_ff;
      sh_win_ff <= (win_h_ff == 12'h000) ? 13'h0001 : {1'b0, win_h_ff}; // RL8
      sh_half_ff <= (roi_h_ff == 12'h000 || roi_h_ff > MAX_ROWS_C) ?
        {1'b0, MAX_ROWS_C} : {1'b0, roi_h_ff}; // RL13
      sh_rows_ff <= (pat_ff == 3'(PAT_SINGLE_DOWN) || pat_ff == 3'(PAT_SINGLE_UP)) ?
        13'((roi_h_ff == 12'h000 || roi_h_ff > MAX_ROWS_C ? MAX_ROWS_C : roi_h_ff) << 1) :
        {1'b0, (roi_h_ff == 12'h000 || roi_h_ff > MAX_ROWS_C ? MAX_ROWS_C : roi_h_ff)}; // RL3
      sh_spd_ff <= clamp_speed(line_spd_ff, fast_ff); // RL9
      sh_min_row_ff <= fast_ff ? ROW_MIN_FAST_C : ROW_MIN_SLOW_C; // RL10
    end
  end
  // Row period from line speed, never shorter than one full row readout
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      period_ff <= ROW_MIN_SLOW_C;
    end else if (div_done) begin
      period_ff <= (div_quot[15:0] < sh_min_row_ff) ? sh_min_row_ff : div_quot[15:0]; // RL12
    end
  end
  // Sequencer state
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
      div_start_ff <= 1'b0;
      dly_cnt_ff <= '0;
      row_cnt_ff <= '0;
      step_ff <= '0;
    end else begin
      div_start_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (acq_en_ff) begin
            div_start_ff <= 1'b1;
            state_ff <= ST_PREP;
          end
        end
        ST_PREP: begin
          if (!acq_en_ff) begin
            state_ff <= ST_IDLE;
          end else if (div_done) begin
            state_ff <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          // Triggers outside this state are ignored
          if (!acq_en_ff) begin
            state_ff <= ST_IDLE;
          end else if (trig_edge) begin
            row_cnt_ff <= '0;
            step_ff <= '0;
            dly_cnt_ff <= sh_dly_ff;
            state_ff <= (sh_dly_ff == 32'h0000_0000) ? ST_SCAN : ST_DELAY; // RL7
          end
        end
        ST_DELAY: begin
          if (!acq_en_ff) begin
            state_ff <= ST_IDLE;
          end else if (dly_cnt_ff == 32'h0000_0001) begin
            state_ff <= ST_SCAN; // RL15
          end else begin
            dly_cnt_ff <= dly_cnt_ff - 32'h0000_0001; // RL15
          end
        end
        ST_SCAN: begin
          // Stopping mid-frame abandons the frame at once
          if (!acq_en_ff) begin
            state_ff <= ST_IDLE;
          end else if (row_cnt_ff == period_ff - 16'h0001) begin
            row_cnt_ff <= '0;
            if (last_step) begin
              state_ff <= ST_ARMED;
            end else begin
              step_ff <= step_ff + 13'h0001;
            end
          end else begin
            row_cnt_ff <= row_cnt_ff + 16'h0001;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  // Direction and frame bookkeeping
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dir_rev_ff <= 1'b0;
      frame_cnt_ff <= '0;
      frame_start_o <= 1'b0;
      frame_done_o <= 1'b0;
    end else begin
      frame_start_o <= row_tick && (step_ff == 13'h0000);
      frame_done_o <= 1'b0;
      if (state_ff == ST_IDLE) begin
        dir_rev_ff <= 1'b0;
      end else if (state_ff == ST_SCAN && acq_en_ff && last_step &&
                   row_cnt_ff == period_ff - 16'h0001) begin
        frame_done_o <= 1'b1;
        frame_cnt_ff <= frame_cnt_ff + 16'h0001;
        if (sh_alt_ff) begin
          dir_rev_ff <= !dir_rev_ff; // RL6
        end
      end
    end
  end
  // Row strobes: reset row leads read row by the window height
  logic [12:0] rd_idx;
  assign rd_idx = step_ff - sh_win_ff;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      row_rst_stb_a_o <= 1'b0;
      row_rst_addr_a_o <= '0;
      row_rd_stb_a_o <= 1'b0;
      row_rd_addr_a_o <= '0;
      row_rst_stb_b_o <= 1'b0;
      row_rst_addr_b_o <= '0;
      row_rd_stb_b_o <= 1'b0;
      row_rd_addr_b_o <= '0;
    end else begin
      row_rst_stb_a_o <= 1'b0;
      row_rd_stb_a_o <= 1'b0;
      row_rst_stb_b_o <= 1'b0;
      row_rd_stb_b_o <= 1'b0;
      if (row_tick) begin
        if (step_ff < sh_rows_ff) begin
          row_rst_stb_a_o <= 1'b1;
          row_rst_addr_a_o <= row_addr(step_ff, 1'b0, sh_pat_ff, dir_rev_ff, sh_half_ff);
          row_rst_stb_b_o <= !single; // RL4
          row_rst_addr_b_o <= row_addr(step_ff, 1'b1, sh_pat_ff, dir_rev_ff, sh_half_ff);
        end
        if (step_ff >= sh_win_ff) begin
          row_rd_stb_a_o <= 1'b1; // RL8
          row_rd_addr_a_o <= row_addr(rd_idx, 1'b0, sh_pat_ff, dir_rev_ff, sh_half_ff);
          row_rd_stb_b_o <= !single; // RL2
          row_rd_addr_b_o <= row_addr(rd_idx, 1'b1, sh_pat_ff, dir_rev_ff, sh_half_ff);
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scan_dir_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      scan_dir_o <= dir_rev_ff;
      busy_o <= (state_ff == ST_DELAY) || (state_ff == ST_SCAN);
    end
  end
  // Register read port: data stand in the cycle after the strobe only
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= '0;
    end else if (rd_stb_i) begin
      case (addr_i)
        `REG_CTRL: rd_data_o <= {26'h0, fast_ff, pat_ff, alt_en_ff, acq_en_ff};
        `REG_TRIG_DLY: rd_data_o <= trig_dly_ff;
        `REG_WIN_H: rd_data_o <= {20'h0, win_h_ff};
        `REG_LINE_SPD: rd_data_o <= {16'h0, line_spd_ff};
        `REG_ROI_H: rd_data_o <= {20'h0, roi_h_ff};
        `REG_STATUS: rd_data_o <= {period_ff, 11'h0, dir_rev_ff, 1'b0, 3'(state_ff)};
        `REG_FRAME_CNT: rd_data_o <= {16'h0, frame_cnt_ff};
        default: rd_data_o <= '0;
      endcase
    end else begin
      rd_data_o <= '0;
    end
  end

endmodule

`default_nettype wire

// ===== inc/rss_defs.svh
// Register offsets, field positions, reset values and timing counts
// of the rolling-shutter scan sequencer. Definitions only.
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// Register byte offsets
`define REG_CTRL      8'h00
`define REG_TRIG_DLY  8'h04
`define REG_WIN_H     8'h08
`define REG_LINE_SPD  8'h0C
`define REG_ROI_H     8'h10
`define REG_STATUS    8'h14
`define REG_FRAME_CNT 8'h18

// Control register fields
`define CTRL_ACQ_EN   0
`define CTRL_ALT_EN   1
`define CTRL_PAT_LO   2
`define CTRL_PAT_HI   4
`define CTRL_FAST     5

// Reset values
`define RST_TRIG_DLY  32'h0000_0000
`define RST_WIN_H     12'h00A
`define RST_LINE_SPD  16'h0BA6
`define FULL_ROWS_HALF 1080

// Line speed is held in hundredths of a row per millisecond
`define SPD_MIN_SLOW  16'h012A
`define SPD_MAX_SLOW  16'h1047
`define SPD_MIN_FAST  16'h02E7
`define SPD_MAX_FAST  16'h28A0

// Timing
`define SYS_CLK_MHZ   40
`define PIX_SLOW_MHZ  216
`define PIX_FAST_MHZ  540
`define ROW_PIX_CLKS  2624
`define CYC_PER_MS    (`SYS_CLK_MHZ * 1000)
`define SPD_NUMER     (`CYC_PER_MS * 100)
// Least row time in system cycles, rounded up
`define ROW_MIN_SLOW  ((`ROW_PIX_CLKS * `SYS_CLK_MHZ + `PIX_SLOW_MHZ - 1) / `PIX_SLOW_MHZ)
`define ROW_MIN_FAST  ((`ROW_PIX_CLKS * `SYS_CLK_MHZ + `PIX_FAST_MHZ - 1) / `PIX_FAST_MHZ)

`endif

// ===== inc/rss_pkg.sv
// Types shared by the scan sequencer design files.
// Assumes rss_defs.svh is available for the numeric constants.
package rss_pkg;

  typedef enum logic [2:0] {
    PAT_CENTRE_OUT,
    PAT_EDGES_IN,
    PAT_BOTH_DOWN,
    PAT_BOTH_UP,
    PAT_SINGLE_DOWN,
    PAT_SINGLE_UP
  } scan_pattern_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREP,
    ST_ARMED,
    ST_DELAY,
    ST_SCAN
  } seq_state_type;

endpackage

// ===== rtl/row_period_div.sv
// Serial restoring divider that turns the line speed into a row period.
// Assumes start is a one-cycle pulse and divisor is held until done.
`timescale 1ns/1ps
`default_nettype none

module row_period_div #(
  parameter int W = 32
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [W-1:0] dividend_i,
  input wire logic [W-1:0] divisor_i,
  output logic [W-1:0] quot_o,
  output logic done_o
);

  generate
    if (W < 2) begin : g_chk
      $error("row_period_div needs W of at least 2");
    end
  endgenerate

  logic [W-1:0] rem_ff;
  logic [W-1:0] quot_ff;
  logic [W-1:0] num_ff;
  logic [$clog2(W+1)-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  logic [W:0] trial;

  assign trial = {rem_ff, num_ff[W-1]} - {1'b0, divisor_i};

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rem_ff <= '0;
      quot_ff <= '0;
      num_ff <= '0;
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start_i) begin
        rem_ff <= '0;
        quot_ff <= '0;
        num_ff <= dividend_i;
        cnt_ff <= ($clog2(W+1))'(W);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        num_ff <= {num_ff[W-2:0], 1'b0};
        if (!trial[W]) begin
          rem_ff <= trial[W-1:0];
          quot_ff <= {quot_ff[W-2:0], 1'b1};
        end else begin
          rem_ff <= {rem_ff[W-2:0], num_ff[W-1]};
          quot_ff <= {quot_ff[W-2:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == ($clog2(W+1))'(1)) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

  assign quot_o = quot_ff;
  assign done_o = done_ff;

endmodule

`default_nettype wire

// ===== verif/scan_sequencer_assertions.sv
// Concurrent checks on the scan sequencer's top-level ports.
// Bound from the testbench top; sees only those ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic rd_stb_i,
  input wire logic [31:0] rd_data_o,
  input wire logic row_rst_stb_a_o,
  input wire logic [ADDR_W-1:0] row_rst_addr_a_o,
  input wire logic row_rst_stb_b_o,
  input wire logic row_rd_stb_a_o,
  input wire logic frame_start_o,
  input wire logic frame_done_o,
  input wire logic scan_dir_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  rd_idle_zero_a: assert property (!$past(rd_stb_i) |-> rd_data_o == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  start_with_reset_a: assert property (frame_start_o |-> row_rst_stb_a_o)
    else $error("frame start without first row reset");
  b_follows_a_a: assert property (row_rst_stb_b_o |-> row_rst_stb_a_o)
    else $error("half b reset strobe without half a");
  row_gap_a: assert property (row_rst_stb_a_o |=> !row_rst_stb_a_o [*8])
    else $error("row reset strobes closer than a row time");
  strobe_busy_a: assert property ((row_rst_stb_a_o || row_rd_stb_a_o) |-> busy_o)
    else $error("row strobe while not busy");
  addr_held_a: assert property (!row_rst_stb_a_o |-> $stable(row_rst_addr_a_o))
    else $error("reset row address moved without strobe");
  dir_held_a: assert property (row_rst_stb_a_o && !frame_start_o |-> $stable(scan_dir_o))
    else $error("scan direction changed inside a frame");
  done_quiet_a: assert property (frame_done_o |=> !row_rst_stb_a_o ##1 !frame_done_o)
    else $error("row reset right after frame end");
  read_late_a: assert property (row_rd_stb_a_o |-> !frame_start_o)
    else $error("row read in first step of frame");

  start_c: cover property (frame_start_o);
  done_c: cover property (frame_done_o);
  dir_rev_c: cover property ($rose(scan_dir_o));
endmodule
`default_nettype wire

// ===== verif/scan_light_source.sv
// Stand-in for the trigger source and light scanner beyond the sensor.
// Assumes fire_i is a one-cycle request from the bench.
`timescale 1ns/1ps
`default_nettype none
module scan_light_source #(
  parameter int TRIG_W = 3
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic fire_i,
  input wire logic row_stb_i,
  input wire logic frame_start_i,
  output logic trig_o,
  output logic [15:0] rows_o
);
  logic trig_ff;
  int hold_ff;
  logic [15:0] rows_ff;
  assign trig_o = trig_ff;
  assign rows_o = rows_ff;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_ff <= 1'b0;
      hold_ff <= 0;
    end else if (fire_i) begin
      trig_ff <= 1'b1;
      hold_ff <= TRIG_W;
    end else if (hold_ff > 1) begin
      hold_ff <= hold_ff - 1;
    end else begin
      trig_ff <= 1'b0;
      hold_ff <= 0;
    end
  end
  // Scanner follows the sensor: one row step per reset strobe, never its own pace
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) rows_ff <= 16'h0000;
    else if (frame_start_i) rows_ff <= 16'h0001;
    else if (row_stb_i) rows_ff <= rows_ff + 16'h0001;
  end
endmodule
`default_nettype wire

// ===== verif/tb_scan_sequencer.sv
// Self-checking bench for the scan sequencer: register access and frames.
// Assumes the sequencer's default parameters and a small region of interest.
`timescale 1ns/1ps
`default_nettype none
module tb_scan_sequencer;
  localparam int H = 4;
  localparam int W = 2;
  localparam int P = 384;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, wr_stb_i = 1'b0, rd_stb_i = 1'b0, fire = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0000_0000, rd_data_o;
  logic trig_i, rst_a, rst_b, rd_a, rd_b, fstart, fdone, dir, busy;
  logic [11:0] rst_a_row, rst_b_row, rd_a_row, rd_b_row;
  logic [15:0] rows;
  logic dir_seen;
  logic [11:0] qa[$], qb[$], qr[$], qrb[$];
  int miscompares = 0, compares = 0, cyc = 0, t_start, t_fire, t_last, t_rd, n_done = 0, t0;

  scan_sequencer u_scan_sequencer (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
    .rd_data_o(rd_data_o), .trig_i(trig_i), .row_rst_stb_a_o(rst_a),
    .row_rst_addr_a_o(rst_a_row), .row_rd_stb_a_o(rd_a), .row_rd_addr_a_o(rd_a_row),
    .row_rst_stb_b_o(rst_b), .row_rst_addr_b_o(rst_b_row), .row_rd_stb_b_o(rd_b),
    .row_rd_addr_b_o(rd_b_row), .frame_start_o(fstart), .frame_done_o(fdone),
    .scan_dir_o(dir), .busy_o(busy));
  scan_light_source u_scan_light_source (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .fire_i(fire), .row_stb_i(rst_a), .frame_start_i(fstart), .trig_o(trig_i),
    .rows_o(rows));

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out();
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_stb_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_stb_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_stb_i <= 1'b0;
    #1 d = rd_data_o;
  endtask

  task automatic wait_state(input logic [2:0] s);
    logic [31:0] d;
    int k;
    k = 0;
    do begin
      rd(8'h14, d);
      k++;
    end while (d[2:0] !== s && k < 100);
    if (d[2:0] !== s) begin
      miscompares++;
      close_out();
    end
  endtask

  function automatic logic [11:0] row_exp(input bit b, input int p, input bit rev, input int i);
    bit dn;
    if (p >= 4) return 12'((((p == 4) ^ rev) != 0) ? i : 2 * H - 1 - i);
    dn = b ? (p == 0 || p == 2) : (p == 1 || p == 2);
    dn = dn ^ rev;
    return 12'((b ? H : 0) + (dn ? i : H - 1 - i));
  endfunction

  // Row order, counts and spacing of one triggered frame
  task automatic frame(input int p, input bit rev);
    int n, k, d0;
    n = (p >= 4) ? 2 * H : H;
    d0 = n_done;
    qa.delete();
    qb.delete();
    qr.delete();
    qrb.delete();
    @(posedge clk_sys_i);
    fire <= 1'b1;
    #1 t_fire = cyc;
    @(posedge clk_sys_i);
    fire <= 1'b0;
    k = 0;
    while (n_done == d0 && k < 6000) begin
      @(posedge clk_sys_i);
      #1 k++;
    end
    if (k >= 6000) begin
      miscompares++;
      close_out();
    end
    chk(qa.size(), n);
    chk(qb.size(), (p >= 4) ? 0 : n);
    chk(qr.size(), n);
    chk(qrb.size(), (p >= 4) ? 0 : n);
    chk({16'h0000, rows}, n);
    chk({31'h0, dir_seen}, {31'h0, rev});
    foreach (qa[i]) chk({20'h0, qa[i]}, {20'h0, row_exp(0, p, rev, i)});
    foreach (qb[i]) chk({20'h0, qb[i]}, {20'h0, row_exp(1, p, rev, i)});
    foreach (qr[i]) chk({20'h0, qr[i]}, {20'h0, row_exp(0, p, rev, i)});
    foreach (qrb[i]) chk({20'h0, qrb[i]}, {20'h0, row_exp(1, p, rev, i)});
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (fstart === 1'b1) begin
      t_start = cyc;
      t_rd = 0;
      dir_seen = dir;
    end
    if (rst_a === 1'b1) begin
      if (fstart !== 1'b1) chk(cyc - t_last, P);
      t_last = cyc;
      qa.push_back(rst_a_row);
    end
    if (rst_b === 1'b1) qb.push_back(rst_b_row);
    if (rd_b === 1'b1) qrb.push_back(rd_b_row);
    if (rd_a === 1'b1) begin
      if (t_rd == 0) chk(cyc - t_start, W * P);
      t_rd = 1;
      qr.push_back(rd_a_row);
    end
    if (fdone === 1'b1) n_done++;
  end

  initial begin
    logic [31:0] d;
    logic [7:0] ra[7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [31:0] rv[7] = '{32'h0, 32'h0000_000A, 32'h0000_0BA6, 32'h0000_0438, 32'h0, 32'h0, 32'h0};
    logic [15:0] sp[3] = '{16'h0064, 16'hFFFF, 16'h0BA6};
    logic [31:0] pe[3] = '{32'h0000_346E, 32'h0000_0180, 32'h0000_053D};
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], d);
      chk(d & ((ra[i] == 8'h14) ? 32'h0000_0007 : 32'hFFFF_FFFF), rv[i]);
    end
    // Speed clamp and row period, slow and fast pixel rates
    for (int i = 0; i < 3; i++) begin
      wr(8'h0C, {16'h0000, sp[i]});
      wr(8'h00, (i == 1) ? 32'h0000_0021 : 32'h0000_0001);
      wait_state(3'h2);
      rd(8'h14, d);
      chk({16'h0000, d[31:16]}, pe[i]);
      wr(8'h00, 32'h0000_0000);
      wait_state(3'h0);
    end
    wr(8'h10, 32'h0000_0004);
    wr(8'h08, 32'h0000_0002);
    wr(8'h0C, 32'h0000_28A0);
    wr(8'h04, 32'h0000_0000);
    // Patterns 0 to 6; pattern 6 falls back to centre-out
    for (int p = 0; p < 7; p++) begin
      wr(8'h00, 32'h0000_0021 | 32'(p << 2));
      wait_state(3'h2);
      frame((p > 5) ? 0 : p, 1'b0);
      wr(8'h00, 32'h0000_0000);
      wait_state(3'h0);
    end
    wr(8'h00, 32'h0000_002B);
    wait_state(3'h2);
    wr(8'h00, 32'h0000_002F);
    frame(2, 1'b0);
    t0 = t_start - t_fire;
    frame(2, 1'b1);
    wr(8'h00, 32'h0000_0000);
    wait_state(3'h0);
    wr(8'h04, 32'h0000_0014);
    wr(8'h00, 32'h0000_0029);
    wait_state(3'h2);
    frame(2, 1'b0);
    chk(t_start - t_fire - t0, 32'h0000_0014);
    rd(8'h18, d);
    chk(d, 32'h0000_000A);
    // Abort in mid-frame: no frame end, count unchanged
    @(posedge clk_sys_i);
    fire <= 1'b1;
    @(posedge clk_sys_i);
    fire <= 1'b0;
    repeat (500) @(posedge clk_sys_i);
    chk({31'h0, busy}, 32'h0000_0001);
    wr(8'h00, 32'h0000_0000);
    wait_state(3'h0);
    repeat (3000) @(posedge clk_sys_i);
    chk({31'h0, busy}, 32'h0000_0000);
    rd(8'h18, d);
    chk(d, 32'h0000_000A);
    chk(n_done, 32'h0000_000A);
    close_out();
  end
endmodule

bind scan_sequencer scan_sequencer_checker #(.ADDR_W(ADDR_W)) u_scan_sequencer_checker (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o),
  .row_rst_stb_a_o(row_rst_stb_a_o), .row_rst_addr_a_o(row_rst_addr_a_o),
  .row_rst_stb_b_o(row_rst_stb_b_o), .row_rd_stb_a_o(row_rd_stb_a_o),
  .frame_start_o(frame_start_o), .frame_done_o(frame_done_o), .scan_dir_o(scan_dir_o),
  .busy_o(busy_o));
`default_nettype wire
